/* File: hw/psr_defs.vh */
/*
 * Constants for the port suspend/resume block: port count, state codes,
 * control-value bit positions, reset values and timing figures.
 * Assumes it is included by its bare name from each design file that uses its constants.
 */
`ifndef PSR_DEFS_VH
`define PSR_DEFS_VH

// ****************************************************************
// Sizes
// ****************************************************************
`define PSR_NP          4
`define PSR_PW          2
`define PSR_TW          25
`define PSR_VW          8
`define PSR_SW          3

// ****************************************************************
// Port states
// ****************************************************************
`define PSR_ST_ACTIVE   3'h0
`define PSR_ST_DROP     3'h1
`define PSR_ST_SUSP     3'h2
`define PSR_ST_RES_INIT 3'h3
`define PSR_ST_RI_WAIT  3'h4
`define PSR_ST_RES_TGT  3'h5
`define PSR_ST_DISABLED 3'h6

// ****************************************************************
// Control value bits and reset values
// ****************************************************************
`define PSR_BIT_SUSPEND 1
`define PSR_BIT_DISABLE 2
`define PSR_RST_SUS     1'h1
`define PSR_RST_DIS     1'h0
`define PSR_RST_CON     1'h0

// ****************************************************************
// Timing
// ****************************************************************
`define PSR_CLK_NS      20
`define PSR_NS_PER_MS   1000000
`define PSR_BIAS_HOLD_CLK 25'h0002000
`define PSR_DETECT_CLK  25'h0002000
`define PSR_DEBOUNCE_MS 85
// One debounce interval of 85 ms at the 20 ns clock
`define PSR_DEBOUNCE_CLK 25'h040D990
`define PSR_DEB_ARB_MULT 25'h0000002
`define PSR_DEB_RES_MULT 25'h0000005
`define PSR_CNT_ZERO    25'h0000000
`define PSR_CNT_ONE     25'h0000001

`endif

/* File: hw/psr_sync.v */
/*
 * Two-flop synchroniser for a bundle of pin levels.
 * Assumes each bit is a slow level; no bit relation is preserved.
 */
module psr_sync #(
    parameter W = 8
) (
    // Clock and reset
    input  wire         mclk,
    input  wire         rst,
    // Levels
    input  wire [W-1:0] din,
    output wire [W-1:0] dout
);

    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end
        else
        begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;

endmodule

/* File: hw/psr_timer.v */
/*
 * Cycle counter with a terminal count given at its input.
 * Assumes start is a one-cycle pulse; done holds until the next start.
 */
`include "psr_defs.vh"

module psr_timer (
    // Clock and reset
    input  wire                 mclk,
    input  wire                 rst,
    // Control
    input  wire                 start,
    input  wire                 run,
    input  wire [`PSR_TW-1:0]   limit,
    // Status
    output wire                 done
);

    reg [`PSR_TW-1:0] cnt_q;

    // Saturates at the limit, so done never wraps back low
    assign done = (cnt_q >= limit);

    always @(posedge mclk or posedge rst)
    begin
        if (rst)
            cnt_q <= `PSR_CNT_ZERO;
        else if (start)
            cnt_q <= `PSR_CNT_ZERO;
        else if (run && !done)
            cnt_q <= cnt_q + `PSR_CNT_ONE;
    end

endmodule

/* File: hw/psr_node.v */
/*
 * Per-port suspend target and resume control for a serial-bus PHY node.
 * Assumes arbitration-state, reset and request indications come from PHY
 * logic on mclk; bias detect and connection sense are pins.
 */
`include "psr_defs.vh"

module psr_node #(
    parameter [`PSR_TW-1:0] BIAS_HOLD_CYC = `PSR_BIAS_HOLD_CLK,
    parameter [`PSR_TW-1:0] DETECT_CYC    = `PSR_DETECT_CLK,
    parameter [`PSR_TW-1:0] DEBOUNCE_CYC  = `PSR_DEBOUNCE_CLK
) (
    // Clock and reset
    input  wire                 mclk,
    input  wire                 rst,
    input  wire                 clk_stable,
    // Register writes
    input  wire                 reg_wr,
    input  wire                 reg_clr,
    input  wire [`PSR_PW-1:0]   reg_port,
    input  wire [`PSR_VW-1:0]   reg_val,
    input  wire                 resume_pkt,
    // Per-port PHY indications
    input  wire [`PSR_NP-1:0]   rx_ident_done,
    input  wire [`PSR_NP-1:0]   expect_selfid,
    input  wire [`PSR_NP-1:0]   rx_short_rst,
    input  wire [`PSR_NP-1:0]   rx_long_rst,
    input  wire [`PSR_NP-1:0]   rx_tx_request,
    // Per-port pins
    input  wire [`PSR_NP-1:0]   bias_det_pin,
    input  wire [`PSR_NP-1:0]   conn_sense_pin,
    output wire [`PSR_NP-1:0]   bias_oe,
    output wire [`PSR_NP-1:0]   bias_hi,
    // Arbitration
    output wire                 arb_req,
    input  wire                 arb_grant,
    // Per-port outputs
    output wire [`PSR_NP-1:0]   suspend,
    output wire [`PSR_NP-1:0]   disable_flag,
    output wire [`PSR_NP-1:0]   connected,
    output wire [`PSR_NP-1:0]   low_power,
    output wire [`PSR_NP-1:0]   repeat_block,
    output wire [`PSR_NP-1:0]   tx_request,
    output wire [`PSR_NP-1:0]   short_rst,
    output wire [`PSR_NP-1:0]   long_rst
);

    // ************************************************************
    // Helpers
    // ************************************************************
    // True when any port other than idx has its bit set
    function other_any;
        input [`PSR_NP-1:0] vec;
        input integer       idx;
        reg   [`PSR_NP-1:0] m;
        begin
            m = vec;
            m[idx] = 1'b0;
            other_any = |m;
        end
    endfunction

    // Bias generator enabled in this state
    function st_bias_en;
        input [`PSR_SW-1:0] st;
        begin
            st_bias_en = (st == `PSR_ST_ACTIVE) || (st == `PSR_ST_DROP) ||
                         (st == `PSR_ST_RES_INIT) ||
                         (st == `PSR_ST_RI_WAIT) ||
                         (st == `PSR_ST_RES_TGT);
        end
    endfunction

    localparam [`PSR_TW-1:0] ARB_WAIT_CYC = DEBOUNCE_CYC * `PSR_DEB_ARB_MULT;
    localparam [`PSR_TW-1:0] RES_WAIT_CYC = DEBOUNCE_CYC * `PSR_DEB_RES_MULT;

    // ************************************************************
    // Pin synchronisation
    // ************************************************************
    wire [`PSR_NP-1:0] bias_in;
    wire [`PSR_NP-1:0] conn;
    reg  [`PSR_NP-1:0] conn_prev_q;

    psr_sync #(
        .W      (2 * `PSR_NP)
    ) u_sync (
        .mclk   (mclk),
        .rst    (rst),
        .din    ({conn_sense_pin, bias_det_pin}),
        .dout   ({conn, bias_in})
    );

    always @(posedge mclk or posedge rst)
    begin
        if (rst)
            conn_prev_q <= {`PSR_NP{1'b0}};
        else
            conn_prev_q <= conn;
    end

    // ************************************************************
    // Node-wide views of the ports
    // ************************************************************
    wire [`PSR_NP-1:0] act_v;
    wire [`PSR_NP-1:0] susp_v;
    wire [`PSR_NP-1:0] ri_v;
    wire [`PSR_NP-1:0] riw_v;
    wire [`PSR_NP-1:0] tgt_v;
    wire [`PSR_NP-1:0] dis_v;
    wire [`PSR_NP-1:0] notify_v;
    wire [`PSR_NP-1:0] tgt_new_v;
    wire [`PSR_NP-1:0] drop_rst_v;
    wire [`PSR_NP-1:0] ri_to_v;
    wire [`PSR_NP-1:0] rx_any_rst;
    wire [`PSR_NP-1:0] resm_v;
    wire [`PSR_NP-1:0] ri_all_v;
    wire               node_win;
    wire               tgt_long;
    wire               arb_done;
    reg                arb_req_q;

    assign rx_any_rst = rx_short_rst | rx_long_rst;
    assign ri_all_v   = ri_v | riw_v;
    assign resm_v     = ri_all_v | tgt_v;
    // Out-of-context ident-done only counts on an enabled active port
    assign notify_v   = act_v & ~dis_v & rx_ident_done & ~expect_selfid;
    // Active ports never become targets, so a resume stops at them
    assign tgt_new_v  = susp_v & ~dis_v & conn & bias_in;
    assign node_win   = arb_req_q & arb_grant;
    assign tgt_long   = |(tgt_v & rx_any_rst);

    // ************************************************************
    // Target arbitration wait, shared by the node
    // ************************************************************
    psr_timer u_arb_tmr (
        .mclk   (mclk),
        .rst    (rst),
        .start  ((|tgt_new_v) && !(|tgt_v)),
        .run    (1'b1),
        .limit  (ARB_WAIT_CYC),
        .done   (arb_done)
    );

    always @(posedge mclk or posedge rst)
    begin
        if (rst)
            arb_req_q <= 1'b0;
        else
            arb_req_q <= arb_done && (|tgt_v) && !tgt_long && !node_win;
    end

    assign arb_req = arb_req_q;

    // ************************************************************
    // Per-port state machines
    // ************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < `PSR_NP; gi = gi + 1)
        begin : g_port
            reg [`PSR_SW-1:0] st_q;
            reg [`PSR_SW-1:0] st_d;
            reg               sus_q;
            reg               sus_d;
            reg               dis_q;
            reg               dis_d;
            reg               con_q;
            reg               con_d;
            reg               low_q;
            reg               low_d;
            reg               oe_q;
            reg               hi_q;
            reg               lp_q;
            reg               blk_q;
            reg               txr_q;
            reg               sr_q;
            reg               lr_q;
            reg               drop_rst;
            reg [`PSR_TW-1:0] lim;
            wire              hit;
            wire              set_sus;
            wire              clr_sus;
            wire              set_dis;
            wire              clr_dis;
            wire              tmr_done;
            wire              short_d;
            wire              long_d;
            wire              txr_d;

            assign hit     = reg_wr && (reg_port == gi);
            assign set_sus = hit && !reg_clr && reg_val[`PSR_BIT_SUSPEND];
            assign clr_sus = hit && reg_clr && reg_val[`PSR_BIT_SUSPEND];
            assign set_dis = hit && !reg_clr && reg_val[`PSR_BIT_DISABLE];
            assign clr_dis = hit && reg_clr && reg_val[`PSR_BIT_DISABLE];

            always @*
            begin
                st_d     = st_q;
                sus_d    = sus_q;
                dis_d    = dis_q;
                con_d    = con_q;
                low_d    = low_q;
                drop_rst = 1'b0;
                case (st_q)
                `PSR_ST_ACTIVE:
                begin
                    low_d = 1'b0;
                    if (set_dis)
                    begin
                        dis_d    = 1'b1;
                        st_d     = `PSR_ST_DROP;
                        drop_rst = 1'b1;
                    end
                    else if (clr_dis)
                    begin
                        dis_d = 1'b1;
                        st_d  = `PSR_ST_DISABLED;
                    end
                    else if (notify_v[gi])
                        st_d = `PSR_ST_DROP;
                    else if (other_any(notify_v, gi) || set_sus)
                    begin
                        sus_d = 1'b1;
                        st_d  = `PSR_ST_DROP;
                    end
                    else if (conn[gi] && !bias_in[gi])
                    begin
                        st_d     = `PSR_ST_DROP;
                        drop_rst = 1'b1;
                    end
                end
                `PSR_ST_DROP:
                begin
                    if (!bias_in[gi])
                    begin
                        sus_d = 1'b1;
                        con_d = 1'b0;
                        low_d = 1'b1;
                    end
                    if (tmr_done)
                    begin
                        sus_d = 1'b1;
                        con_d = 1'b0;
                        st_d  = `PSR_ST_SUSP;
                        if (!low_q && bias_in[gi] && conn[gi])
                            dis_d = 1'b1;
                    end
                end
                `PSR_ST_SUSP:
                begin
                    // Resets on this port are not looked at here
                    if (dis_q)
                    begin
                        if (!conn[gi] || clr_dis)
                            dis_d = 1'b0;
                    end
                    else if (tgt_new_v[gi])
                    begin
                        sus_d = 1'b0;
                        con_d = 1'b1;
                        st_d  = `PSR_ST_RES_TGT;
                    end
                    // A new target wakes every enabled port, cable or not
                    else if (other_any(tgt_new_v, gi) ||
                             (conn[gi] &&
                              (clr_sus || resume_pkt ||
                               !conn_prev_q[gi])))
                    begin
                        sus_d = 1'b0;
                        st_d  = `PSR_ST_RES_INIT;
                    end
                end
                `PSR_ST_RES_INIT:
                begin
                    if (rx_any_rst[gi])
                        st_d = `PSR_ST_ACTIVE;
                    else if (bias_in[gi])
                    begin
                        con_d = 1'b1;
                        st_d  = `PSR_ST_RI_WAIT;
                    end
                    else if (tmr_done)
                    begin
                        dis_d = 1'b1;
                        st_d  = `PSR_ST_DISABLED;
                    end
                end
                `PSR_ST_RI_WAIT:
                begin
                    if (rx_any_rst[gi] || tmr_done)
                        st_d = `PSR_ST_ACTIVE;
                end
                `PSR_ST_RES_TGT:
                begin
                    if (tgt_long || node_win)
                        st_d = `PSR_ST_ACTIVE;
                end
                `PSR_ST_DISABLED:
                begin
                    // Stuck until node reset: events are ignored
                    st_d = `PSR_ST_DISABLED;
                end
                default:
                    st_d = `PSR_ST_ACTIVE;
                endcase
            end

            // Detect counts only on a stable clock; other waits always run
            always @*
            begin
                case (st_q)
                `PSR_ST_DROP:     lim = BIAS_HOLD_CYC;
                `PSR_ST_RES_INIT: lim = DETECT_CYC;
                default:          lim = RES_WAIT_CYC;
                endcase
            end

            psr_timer u_tmr (
                .mclk   (mclk),
                .rst    (rst),
                .start  (st_d != st_q),
                .run    (clk_stable || (st_q != `PSR_ST_RES_INIT)),
                .limit  (lim),
                .done   (tmr_done)
            );

            assign short_d =
                (act_v[gi] && (st_d == `PSR_ST_ACTIVE) &&
                 other_any(drop_rst_v, gi)) ||
                (node_win && (act_v[gi] || tgt_v[gi])) ||
                (resm_v[gi] && other_any(ri_all_v & rx_short_rst, gi));
            assign long_d =
                (tgt_long && (act_v[gi] || tgt_v[gi])) ||
                ri_to_v[gi] || (resm_v[gi] && other_any(ri_to_v, gi)) ||
                (resm_v[gi] && other_any(ri_all_v & rx_long_rst, gi));
            assign txr_d =
                (st_d == `PSR_ST_RES_TGT) ||
                (resm_v[gi] && other_any(ri_all_v & rx_tx_request, gi));

            always @(posedge mclk or posedge rst)
            begin
                if (rst)
                begin
                    st_q  <= `PSR_ST_SUSP;
                    sus_q <= `PSR_RST_SUS;
                    dis_q <= `PSR_RST_DIS;
                    con_q <= `PSR_RST_CON;
                    low_q <= 1'b0;
                    oe_q  <= 1'b0;
                    hi_q  <= 1'b0;
                    lp_q  <= 1'b1;
                    blk_q <= 1'b0;
                    txr_q <= 1'b0;
                    sr_q  <= 1'b0;
                    lr_q  <= 1'b0;
                end
                else
                begin
                    st_q  <= st_d;
                    sus_q <= sus_d;
                    dis_q <= dis_d;
                    con_q <= con_d;
                    low_q <= (st_d == `PSR_ST_DROP) ? low_d : 1'b0;
                    oe_q  <= st_bias_en(st_d);
                    hi_q  <= st_bias_en(st_d) && (st_d != `PSR_ST_DROP);
                    lp_q  <= (st_d == `PSR_ST_SUSP);
                    blk_q <= (st_d == `PSR_ST_RES_TGT);
                    txr_q <= txr_d;
                    sr_q  <= short_d;
                    lr_q  <= long_d && !short_d;
                end
            end

            assign act_v[gi]      = (st_q == `PSR_ST_ACTIVE);
            assign susp_v[gi]     = (st_q == `PSR_ST_SUSP);
            assign ri_v[gi]       = (st_q == `PSR_ST_RES_INIT);
            assign riw_v[gi]      = (st_q == `PSR_ST_RI_WAIT);
            assign tgt_v[gi]      = (st_q == `PSR_ST_RES_TGT);
            assign dis_v[gi]      = dis_q;
            assign drop_rst_v[gi] = drop_rst;
            assign ri_to_v[gi]    = riw_v[gi] && tmr_done && !rx_any_rst[gi];
            assign suspend[gi]      = sus_q;
            assign disable_flag[gi] = dis_q;
            assign connected[gi]    = con_q;
            assign low_power[gi]    = lp_q;
            assign repeat_block[gi] = blk_q;
            assign tx_request[gi]   = txr_q;
            assign short_rst[gi]    = sr_q;
            assign long_rst[gi]     = lr_q;
            assign bias_oe[gi]      = oe_q;
            assign bias_hi[gi]      = hi_q;
        end
    endgenerate

endmodule

/* File: hw/psr_unused_none.v */
/*
 * Holds no logic; the block lives in the other design files.
 */

/* File: tb/psr_sva.sv */
/* Checker for psr_node: port-level timing of suspend and resume.
   Bound to every psr_node; sees only its ports. */
module psr_sva #(
    parameter int BIAS_HOLD_CYC = 8,
    parameter int DEBOUNCE_CYC  = 20
) (
    // Clock and reset
    input logic       mclk,
    input logic       rst,
    // Watched inputs
    input logic [3:0] rx_ident_done,
    input logic [3:0] expect_selfid,
    input logic [3:0] rx_short_rst,
    input logic [3:0] bias_det_pin,
    input logic       arb_grant,
    // Watched outputs
    input logic [3:0] bias_oe,
    input logic [3:0] bias_hi,
    input logic       arb_req,
    input logic [3:0] suspend,
    input logic [3:0] disable_flag,
    input logic [3:0] connected,
    input logic [3:0] low_power,
    input logic [3:0] repeat_block,
    input logic [3:0] tx_request,
    input logic [3:0] short_rst,
    input logic [3:0] long_rst
);
    // ********
    // Interval counters
    // ********
    // Counters instead of long repetitions keep the tools quick
    int hold_q;
    int arb_q;
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            hold_q <= 0;
            arb_q  <= 0;
        end
        else
        begin
            hold_q <= (bias_oe[0] && !bias_hi[0]) ? hold_q + 1 : 0;
            arb_q  <= (|repeat_block) ? arb_q + 1 : 0;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_notify_bias_low: assert property (
        rx_ident_done[0] && !expect_selfid[0] && connected[0] && !suspend[0]
        && !disable_flag[0] && !repeat_block[0] |=> bias_oe[0] && !bias_hi[0])
        else $error("notification did not drive bias low");
    a_hold_bound: assert property (
        hold_q <= BIAS_HOLD_CYC + 3)
        else $error("low bias held past the hold period");
    a_low_bias_sus: assert property (
        $fell(bias_det_pin[0]) && bias_oe[0] && !bias_hi[0]
        |-> ##[2:4] suspend[0] && !connected[0])
        else $error("low incoming bias did not complete suspend");
    a_lp_no_bias: assert property (
        (low_power & bias_oe) == 4'h0)
        else $error("low-power port drives bias");
    a_dis_quiet: assert property (
        (disable_flag & ~suspend & (bias_hi | tx_request)) == 4'h0)
        else $error("disabled port still signals");
    a_tgt_answer: assert property (
        $rose(repeat_block[0])
        |-> bias_oe[0] && bias_hi[0] && !suspend[0] && connected[0])
        else $error("resume target did not answer with bias");
    a_tgt_txreq: assert property (
        $rose(repeat_block[0]) |-> ##[0:2] tx_request[0])
        else $error("resume target sent no request");
    a_arb_wait: assert property (
        $rose(arb_req) |-> arb_q >= 2 * DEBOUNCE_CYC - 3
        && arb_q <= 2 * DEBOUNCE_CYC + 3)
        else $error("arbitration not after two debounce intervals");
    a_grant_short: assert property (
        arb_req && arb_grant && repeat_block[0] |=> short_rst[0])
        else $error("grant gave no short reset to target");
    a_early_long: assert property (
        repeat_block[0] && !arb_req && rx_short_rst[0] |-> ##[1:2] long_rst[0])
        else $error("early reset on target gave no long reset");
    c_target: cover property ($rose(repeat_block[0]));
    c_long: cover property ($rose(|long_rst));
    c_disable: cover property ($rose(disable_flag[1]));
endmodule

bind psr_node psr_sva #(
    .BIAS_HOLD_CYC(BIAS_HOLD_CYC),
    .DEBOUNCE_CYC (DEBOUNCE_CYC)
) u_sva (
    .mclk, .rst, .rx_ident_done, .expect_selfid, .rx_short_rst,
    .bias_det_pin, .arb_grant, .bias_oe, .bias_hi, .arb_req, .suspend,
    .disable_flag, .connected, .low_power, .repeat_block, .tx_request,
    .short_rst, .long_rst
);

/* File: tb/psr_peer.sv */
/* Behavioural far-end ports, one per node port, with fixed latency.
   Bench drives plug and wake shortly after each mclk edge. */
module psr_peer #(
    parameter int LAT = 3
) (
    // Clock
    input  logic       mclk,
    // Bench control
    input  logic [3:0] plug,
    input  logic [3:0] wake,
    // Cable side
    input  logic [3:0] bias_oe,
    input  logic [3:0] bias_hi,
    output logic [3:0] bias_det,
    output logic [3:0] conn
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] awake_q = 4'h0;
    logic [3:0] pipe_q [LAT] = '{default: 4'h0};
    // Wake starts a resume; low bias from the node suspends the peer,
    // which drops its own bias back; high bias from the node wakes it
    always @(posedge mclk)
    begin
        awake_q <= wake | (bias_oe & bias_hi)
            | (awake_q & ~(bias_oe & ~bias_hi));
        pipe_q[0] <= awake_q;
        for (int k = 1; k < LAT; k++)
            pipe_q[k] <= pipe_q[k-1];
    end
    // An unplugged cable shows neither bias nor connection
    assign bias_det = pipe_q[LAT-1] & plug;
    assign conn     = plug;
endmodule

/* File: tb/tb.sv */
/* Self-checking bench for psr_node with short timing parameters.
   Assumes psr_peer models the far ends and psr_sva is bound. */
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin failures++; \
    $display("unexpected %s: expected %0h seen %0h", n, e, s); end end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int BH = 8;
    localparam int DT = 8;
    localparam int DB = 20;
    int failures = 0;
    int compares = 0;
    int k;
    logic mclk = 0, rst = 1, clk_stable = 1, arb_req;
    logic reg_wr = 0, reg_clr = 0, resume_pkt = 0, arb_grant = 0;
    logic [1:0] reg_port = 2'h0;
    logic [7:0] reg_val = 8'h00;
    logic [3:0] rx_ident_done = 4'h0, expect_selfid = 4'h0;
    logic [3:0] rx_short_rst = 4'h0, rx_long_rst = 4'h0;
    logic [3:0] rx_tx_request = 4'h0, plug = 4'h0, wake = 4'h0;
    logic [3:0] sr_seen = 4'h0, lr_seen = 4'h0, bias_det_pin;
    logic [3:0] conn_sense_pin, bias_oe, bias_hi, suspend, disable_flag;
    logic [3:0] connected, low_power, repeat_block, tx_request;
    logic [3:0] short_rst, long_rst;
    psr_node #(.BIAS_HOLD_CYC(BH), .DETECT_CYC(DT), .DEBOUNCE_CYC(DB)) dut (.*);
    psr_peer #(.LAT(3)) peer (.mclk, .plug, .wake, .bias_oe, .bias_hi,
        .bias_det(bias_det_pin), .conn(conn_sense_pin));
    always #10 mclk = ~mclk;
    // Reset pulses last one cycle, so they are caught as they pass
    logic seen_clr = 0;
    always @(posedge mclk)
    begin
        sr_seen <= seen_clr ? 4'h0 : sr_seen | short_rst;
        lr_seen <= seen_clr ? 4'h0 : lr_seen | long_rst;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic do_reset;
        rst = 1;
        cyc(10);
        rst = 0;
        cyc(2);
    endtask
    task automatic wr(input logic c, input logic [1:0] p, input logic [7:0] v);
        reg_wr = 1;
        reg_clr = c;
        reg_port = p;
        reg_val = v;
        cyc(1);
        reg_wr = 0;
    endtask
    task automatic test_done;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        #40000;
        failures++;
        $display("watchdog expired");
        test_done;
    end
    initial
    begin
        void'($urandom(75));
        do_reset;
        `CHK("suspend", 4'hF, suspend);
        `CHK("low_power", 4'hF, low_power);
        `CHK("bias_oe", 4'h0, bias_oe);
        $display("test power-up done");
        wake = 4'h1;
        cyc(1);
        wake = 4'h0;
        cyc(4);
        plug = 4'h1;
        cyc(5);
        `CHK("tgt suspend", 4'h0, suspend);
        `CHK("tgt bias", 3'h7, {connected[0], bias_oe[0], bias_hi[0]});
        `CHK("tgt req", 2'h3, {tx_request[0], repeat_block[0]});
        rx_tx_request = 4'h2;
        cyc(1);
        `CHK("fwd req", 2'h3, tx_request[3:2]);
        rx_tx_request = 4'h0;
        cyc(DT + 4);
        `CHK("ri dis", 6'h38, {disable_flag[3:1], bias_oe[3:1]});
        for (k = 0; k < 3 * DB && arb_req !== 1'b1; k++)
            cyc(1);
        `CHK("arb_req", 1'h1, arb_req);
        seen_clr = 1;
        arb_grant = 1;
        cyc(1);
        arb_grant = 0;
        seen_clr = 0;
        cyc(2);
        `CHK("grant rst", 2'h1, {repeat_block[0], sr_seen[0]});
        $display("test resume target done");
        for (int i = 0; i < 24; i++)
        begin
            plug[3:1] = 3'($urandom);
            wr(1'($urandom), 2'($urandom_range(3, 1)), 8'($urandom));
            cyc(1);
        end
        plug[3:1] = 3'h0;
        cyc(4);
        `CHK("dis flags", 6'h38, {disable_flag[3:1], suspend[3:1]});
        `CHK("dis quiet", 3'h0, bias_hi[3:1] | tx_request[3:1]);
        $display("test disabled ports done");
        expect_selfid = 4'h1;
        rx_ident_done = 4'h1;
        cyc(1);
        rx_ident_done = 4'h0;
        cyc(2);
        `CHK("child done", 2'h3, {bias_oe[0], bias_hi[0]});
        expect_selfid = 4'h0;
        rx_ident_done = 4'h1;
        cyc(1);
        rx_ident_done = 4'h0;
        cyc(1);
        `CHK("notify bias", 2'h2, {bias_oe[0], bias_hi[0]});
        cyc(8);
        `CHK("notify flags", 2'h2, {suspend[0], connected[0]});
        cyc(BH);
        `CHK("parked", 3'h2, {bias_oe[0], low_power[0], disable_flag[0]});
        $display("test suspend target done");
        seen_clr = 1;
        if ($urandom % 2)
            wr(1'h1, 2'h0, 8'h02);
        else
        begin
            resume_pkt = 1;
            cyc(1);
            resume_pkt = 0;
        end
        seen_clr = 0;
        cyc(1);
        `CHK("ri bias", 3'h3, {suspend[0], bias_oe[0], bias_hi[0]});
        cyc(8);
        `CHK("ri con", 2'h1, {disable_flag[0], connected[0]});
        for (k = 0; k < 5 * DB + 12 && lr_seen[0] !== 1'b1; k++)
            cyc(1);
        `CHK("ri long", 2'h3, {lr_seen[0], k >= 5 * DB - 14});
        $display("test resume initiator done");
        do_reset;
        cyc(4);
        `CHK("tgt again", 1'h1, repeat_block[0]);
        seen_clr = 1;
        if ($urandom % 2)
            rx_short_rst = 4'h1;
        else
            rx_long_rst = 4'h1;
        cyc(1);
        rx_short_rst = 4'h0;
        rx_long_rst = 4'h0;
        seen_clr = 0;
        cyc(2);
        `CHK("early long", 1'h1, lr_seen[0]);
        cyc(4);
        wr(1'h1, 2'h0, 8'h04);
        cyc(1);
        `CHK("clr dis", 2'h2, {disable_flag[0], bias_hi[0]});
        $display("test early reset done");
        test_done;
    end
endmodule
